// *** hw/msx_pkg.sv ***
// Constants, opcodes and register map of the swap, skip, table and xor execution unit
// Assumes a single 50 MHz clock and an APB register port with 32-bit data
package msx_pkg;

	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int DW      = 8;
	localparam int DA_W    = 6;
	localparam int DMEM_N  = 64;
	localparam int PA_W    = 10;
	localparam int PW      = 16;
	localparam int PAGE_W  = 2;
	localparam int OPC_W   = 4;
	localparam int BIT_W   = 3;
	localparam int PADDR_W = 8;
	localparam int PDATA_W = 32;
	localparam int PMEM_N  = 1024;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [PADDR_W-1:0] REG_INSTR  = 8'h00;
	localparam logic [PADDR_W-1:0] REG_ACC    = 8'h04;
	localparam logic [PADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [PADDR_W-1:0] REG_TPLOW  = 8'h0C;
	localparam logic [PADDR_W-1:0] REG_TPHIGH = 8'h10;
	localparam logic [PADDR_W-1:0] REG_THLAT  = 8'h14;
	localparam logic [PADDR_W-1:0] REG_PC     = 8'h18;
	localparam logic [PADDR_W-1:0] REG_DPTR   = 8'h1C;
	localparam logic [PADDR_W-1:0] REG_DDATA  = 8'h20;
	localparam logic [PADDR_W-1:0] REG_PPTR   = 8'h24;
	localparam logic [PADDR_W-1:0] REG_PDATA  = 8'h28;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OPC_LSB    = 0;
	localparam int BIT_LSB    = 4;
	localparam int ADDR_LSB   = 8;
	localparam int IMM_LSB    = 16;
	localparam int ST_Z_BIT   = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_SKIP_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values and steps
	// ----------------------------------------------------------------
	localparam logic [DW-1:0]     BYTE_RST  = 8'h00;
	localparam logic [PA_W-1:0]   PC_RST    = 10'h000;
	localparam logic [PA_W-1:0]   PC_STEP   = 10'h001;
	localparam logic [PAGE_W-1:0] LAST_PAGE = 2'h3;
	localparam logic [DW-1:0]     BYTE_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [OPC_W-1:0] OP_NOP                = 4'h0;
	localparam logic [OPC_W-1:0] OP_NIBBLE_SWAP_TO_ACC = 4'h1;
	localparam logic [OPC_W-1:0] OP_SKIP_IF_NULL       = 4'h2;
	localparam logic [OPC_W-1:0] OP_COPY_AND_SKIP      = 4'h3;
	localparam logic [OPC_W-1:0] OP_SKIP_IF_BIT_NULL   = 4'h4;
	localparam logic [OPC_W-1:0] OP_TABLE_READ_SPECIFIC = 4'h5;
	localparam logic [OPC_W-1:0] OP_TABLE_READ_CURRENT = 4'h6;
	localparam logic [OPC_W-1:0] OP_TABLE_READ_LAST    = 4'h7;
	localparam logic [OPC_W-1:0] OP_XOR_TO_ACC         = 4'h8;
	localparam logic [OPC_W-1:0] OP_EXCLUSIVE_OR_TO_MEMORY = 4'h9;
	localparam logic [OPC_W-1:0] OP_XOR_IMMEDIATE      = 4'hA;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_DUMMY
	} msx_state_type;

endpackage

// *** hw/msx_if.sv ***
// Operand and result bundle between the sequencer and the execution datapath
// Assumes both ends sit on the same clock
`timescale 1ns/10ps
interface msx_if;
	import msx_pkg::*;

	logic [OPC_W-1:0] opcode;
	logic [BIT_W-1:0] bit_sel;
	logic [DW-1:0]    mem_val;
	logic [DW-1:0]    acc_val;
	logic [DW-1:0]    imm_val;
	logic [PW-1:0]    prog_word;
	logic             acc_we;
	logic [DW-1:0]    acc_res;
	logic             mem_we;
	logic [DW-1:0]    mem_res;
	logic             thl_we;
	logic [DW-1:0]    thl_res;
	logic             z_we;
	logic             z_res;
	logic             skip;
	logic             table_op;

	modport core (
		output opcode, bit_sel, mem_val, acc_val, imm_val, prog_word,
		input  acc_we, acc_res, mem_we, mem_res, thl_we, thl_res,
		input  z_we, z_res, skip, table_op
	);
	modport alu (
		input  opcode, bit_sel, mem_val, acc_val, imm_val, prog_word,
		output acc_we, acc_res, mem_we, mem_res, thl_we, thl_res,
		output z_we, z_res, skip, table_op
	);
endinterface

// *** hw/msx_alu.sv ***
// Combinational execution datapath for one decoded instruction
// Assumes operands are stable for the whole execute cycle
`timescale 1ns/10ps
module msx_alu
	import msx_pkg::*;
(
	msx_if.alu bus
);

	logic [DW-1:0] xor_mem;
	logic [DW-1:0] xor_imm;

	always_comb begin
		xor_mem      = bus.acc_val ^ bus.mem_val;
		xor_imm      = bus.acc_val ^ bus.imm_val;
		bus.acc_we   = 1'b0;
		bus.acc_res  = bus.acc_val;
		bus.mem_we   = 1'b0;
		bus.mem_res  = bus.mem_val;
		bus.thl_we   = 1'b0;
		bus.thl_res  = bus.prog_word[PW-1:DW];
		bus.z_we     = 1'b0;
		bus.z_res    = 1'b0;
		bus.skip     = 1'b0;
		bus.table_op = 1'b0;
		case (bus.opcode)
			OP_NIBBLE_SWAP_TO_ACC: begin
				bus.acc_we  = 1'b1;
				bus.acc_res = {bus.mem_val[DW/2-1:0], bus.mem_val[DW-1:DW/2]};
			end
			OP_SKIP_IF_NULL: begin
				bus.skip = (bus.mem_val == BYTE_ZERO);
			end
			OP_COPY_AND_SKIP: begin
				bus.acc_we  = 1'b1;
				bus.acc_res = bus.mem_val;
				bus.skip    = (bus.mem_val == BYTE_ZERO);
			end
			OP_SKIP_IF_BIT_NULL: begin
				bus.skip = ~bus.mem_val[bus.bit_sel];
			end
			OP_TABLE_READ_SPECIFIC,
			OP_TABLE_READ_CURRENT,
			OP_TABLE_READ_LAST: begin
				bus.table_op = 1'b1;
				bus.mem_we   = 1'b1;
				bus.mem_res  = bus.prog_word[DW-1:0];
				bus.thl_we   = 1'b1;
			end
			OP_XOR_TO_ACC: begin
				bus.acc_we  = 1'b1;
				bus.acc_res = xor_mem;
				bus.z_we    = 1'b1;
				bus.z_res   = (xor_mem == BYTE_ZERO);
			end
			OP_EXCLUSIVE_OR_TO_MEMORY: begin
				bus.mem_we  = 1'b1;
				bus.mem_res = xor_mem;
				bus.z_we    = 1'b1;
				bus.z_res   = (xor_mem == BYTE_ZERO);
			end
			OP_XOR_IMMEDIATE: begin
				bus.acc_we  = 1'b1;
				bus.acc_res = xor_imm;
				bus.z_we    = 1'b1;
				bus.z_res   = (xor_imm == BYTE_ZERO);
			end
			default: begin
				bus.acc_we = 1'b0;
			end
		endcase
	end

endmodule

// *** hw/msx_core.sv ***
// Execution unit for nibble swap, zero skips, table reads and xor, APB controlled
// Assumes an APB master on sys_clk_i; memories are internal and APB reachable
// Overview of operation
// - Nibble swap puts byte halves exchanged into accumulator, memory and zero flag kept, skip flag cleared.
// - Skip-if-null skips next instruction when addressed byte is zero, zero flag kept, skip flag set to the outcome.
// - A taken skip adds one dummy cycle, making the instruction two cycles.
// - Copy-and-skip copies byte to accumulator, skips when it is zero.
// - Bit-test skip skips when selected bit is zero, zero flag kept, skip flag set to the outcome.
// - Specific-page table read uses both table pointers for program address.
// - Current-page table read uses current page and low table pointer.
// - Last-page table read uses last page and low table pointer.
// - Table reads leave the zero flag unchanged and clear the skip flag.
// - Xor from memory writes accumulator, changes zero flag and clears skip flag.
// - Xor to memory writes data byte, changes zero flag and clears skip flag.
// - Xor immediate writes accumulator, changes zero flag and clears skip flag.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
module msx_core
	import msx_pkg::*;
(
	input  wire logic               sys_clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [PADDR_W-1:0] paddr_i,
	input  wire logic [PDATA_W-1:0] pwdata_i,
	output logic      [PDATA_W-1:0] prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	output logic                    busy_o
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [DW-1:0] dmem [DMEM_N];
	logic [PW-1:0] pmem [PMEM_N];

	msx_state_type    state_q, state_d;
	logic [OPC_W-1:0] opc_q, opc_d;
	logic [BIT_W-1:0] bit_q, bit_d;
	logic [DA_W-1:0]  maddr_q, maddr_d;
	logic [DW-1:0]    imm_q, imm_d;
	logic [DW-1:0]    acc_q, acc_d;
	logic             z_q, z_d;
	logic             skip_q, skip_d;
	logic [DW-1:0]    table_high_latch_q, table_high_latch_d;
	logic [DW-1:0]    table_pointer_low_q, table_pointer_low_d;
	logic [DW-1:0]    table_pointer_high_q, table_pointer_high_d;
	logic [PA_W-1:0]  pc_q, pc_d;
	logic [DA_W-1:0]  dptr_q, dptr_d;
	logic [PA_W-1:0]  pptr_q, pptr_d;
	logic [PDATA_W-1:0] prdata_d;
	logic             pready_d;
	logic             pslverr_d;

	logic             apb_wr;
	logic             apb_setup;
	logic             dmem_we;
	logic [DA_W-1:0]  dmem_wa;
	logic [DW-1:0]    dmem_wd;
	logic             pmem_we;
	logic [PA_W-1:0]  table_addr;

	msx_if alu_bus ();

	msx_alu u_alu (
		.bus (alu_bus.alu)
	);

	// ----------------------------------------------------------------
	// Table address selection
	// ----------------------------------------------------------------
	always_comb begin
		table_addr = {pc_q[PA_W-1 -: PAGE_W], table_pointer_low_q};
		case (opc_q)
			OP_TABLE_READ_SPECIFIC: begin
				table_addr = {table_pointer_high_q[PAGE_W-1:0], table_pointer_low_q};
			end
			OP_TABLE_READ_CURRENT: begin
				table_addr = {pc_q[PA_W-1 -: PAGE_W], table_pointer_low_q};
			end
			OP_TABLE_READ_LAST: begin
				table_addr = {LAST_PAGE, table_pointer_low_q};
			end
			default: begin
				table_addr = {pc_q[PA_W-1 -: PAGE_W], table_pointer_low_q};
			end
		endcase
	end

	assign alu_bus.opcode    = opc_q;
	assign alu_bus.bit_sel   = bit_q;
	assign alu_bus.mem_val   = dmem[maddr_q];
	assign alu_bus.acc_val   = acc_q;
	assign alu_bus.imm_val   = imm_q;
	assign alu_bus.prog_word = pmem[table_addr];

	assign apb_wr    = psel_i & penable_i & pwrite_i & pready_o;
	assign apb_setup = psel_i & ~penable_i;

	// ----------------------------------------------------------------
	// Sequencer and register writes
	// ----------------------------------------------------------------
	always_comb begin
		state_d              = state_q;
		opc_d                = opc_q;
		bit_d                = bit_q;
		maddr_d              = maddr_q;
		imm_d                = imm_q;
		acc_d                = acc_q;
		z_d                  = z_q;
		skip_d               = skip_q;
		table_high_latch_d   = table_high_latch_q;
		table_pointer_low_d  = table_pointer_low_q;
		table_pointer_high_d = table_pointer_high_q;
		pc_d                 = pc_q;
		dptr_d               = dptr_q;
		pptr_d               = pptr_q;
		dmem_we              = 1'b0;
		dmem_wa              = dptr_q;
		dmem_wd              = pwdata_i[DW-1:0];
		pmem_we              = 1'b0;
		if (apb_wr) begin
			if (paddr_i == REG_INSTR) begin
				if (state_q == ST_IDLE) begin
					opc_d   = pwdata_i[OPC_LSB +: OPC_W];
					bit_d   = pwdata_i[BIT_LSB +: BIT_W];
					maddr_d = pwdata_i[ADDR_LSB +: DA_W];
					imm_d   = pwdata_i[IMM_LSB +: DW];
					state_d = ST_EXEC;
				end
			end else if (paddr_i == REG_ACC) begin
				acc_d = pwdata_i[DW-1:0];
			end else if (paddr_i == REG_STATUS) begin
				z_d = pwdata_i[ST_Z_BIT];
			end else if (paddr_i == REG_TPLOW) begin
				table_pointer_low_d = pwdata_i[DW-1:0];
			end else if (paddr_i == REG_TPHIGH) begin
				table_pointer_high_d = pwdata_i[DW-1:0];
			end else if (paddr_i == REG_PC) begin
				pc_d = pwdata_i[PA_W-1:0];
			end else if (paddr_i == REG_DPTR) begin
				dptr_d = pwdata_i[DA_W-1:0];
			end else if (paddr_i == REG_DDATA) begin
				dmem_we = 1'b1;
			end else if (paddr_i == REG_PPTR) begin
				pptr_d = pwdata_i[PA_W-1:0];
			end else if (paddr_i == REG_PDATA) begin
				pmem_we = 1'b1;
			end
		end
		case (state_q)
			ST_IDLE: begin
				skip_d = skip_q;
			end
			ST_EXEC: begin
				if (alu_bus.acc_we) begin
					acc_d = alu_bus.acc_res;
				end
				if (alu_bus.z_we) begin
					z_d = alu_bus.z_res;
				end
				if (alu_bus.thl_we && alu_bus.table_op) begin
					table_high_latch_d = alu_bus.thl_res;
				end
				if (alu_bus.mem_we) begin
					dmem_we = 1'b1;
					dmem_wa = maddr_q;
					dmem_wd = alu_bus.mem_res;
				end
				pc_d   = pc_q + PC_STEP;
				skip_d = alu_bus.skip;
				if (alu_bus.skip) begin
					state_d = ST_DUMMY;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_DUMMY: begin
				pc_d    = pc_q + PC_STEP;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q              <= ST_IDLE;
			opc_q                <= OP_NOP;
			bit_q                <= '0;
			maddr_q              <= '0;
			imm_q                <= BYTE_RST;
			acc_q                <= BYTE_RST;
			z_q                  <= 1'b0;
			skip_q               <= 1'b0;
			table_high_latch_q   <= BYTE_RST;
			table_pointer_low_q  <= BYTE_RST;
			table_pointer_high_q <= BYTE_RST;
			pc_q                 <= PC_RST;
			dptr_q               <= '0;
			pptr_q               <= PC_RST;
		end else begin
			state_q              <= state_d;
			opc_q                <= opc_d;
			bit_q                <= bit_d;
			maddr_q              <= maddr_d;
			imm_q                <= imm_d;
			acc_q                <= acc_d;
			z_q                  <= z_d;
			skip_q               <= skip_d;
			table_high_latch_q   <= table_high_latch_d;
			table_pointer_low_q  <= table_pointer_low_d;
			table_pointer_high_q <= table_pointer_high_d;
			pc_q                 <= pc_d;
			dptr_q               <= dptr_d;
			pptr_q               <= pptr_d;
		end
	end

	// ----------------------------------------------------------------
	// Memory write ports
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (dmem_we) begin
			dmem[dmem_wa] <= dmem_wd;
		end
		if (pmem_we) begin
			pmem[pptr_q] <= pwdata_i[PW-1:0];
		end
	end

	// ----------------------------------------------------------------
	// APB read and response
	// ----------------------------------------------------------------
	always_comb begin
		prdata_d  = '0;
		pready_d  = apb_setup;
		pslverr_d = 1'b0;
		if (apb_setup) begin
			if (paddr_i == REG_INSTR) begin
				prdata_d = '0;
			end else if (paddr_i == REG_ACC) begin
				prdata_d[DW-1:0] = acc_q;
			end else if (paddr_i == REG_STATUS) begin
				prdata_d[ST_Z_BIT]    = z_q;
				prdata_d[ST_BUSY_BIT] = (state_q != ST_IDLE);
				prdata_d[ST_SKIP_BIT] = skip_q;
			end else if (paddr_i == REG_TPLOW) begin
				prdata_d[DW-1:0] = table_pointer_low_q;
			end else if (paddr_i == REG_TPHIGH) begin
				prdata_d[DW-1:0] = table_pointer_high_q;
			end else if (paddr_i == REG_THLAT) begin
				prdata_d[DW-1:0] = table_high_latch_q;
			end else if (paddr_i == REG_PC) begin
				prdata_d[PA_W-1:0] = pc_q;
			end else if (paddr_i == REG_DPTR) begin
				prdata_d[DA_W-1:0] = dptr_q;
			end else if (paddr_i == REG_DDATA) begin
				prdata_d[DW-1:0] = dmem[dptr_q];
			end else if (paddr_i == REG_PPTR) begin
				prdata_d[PA_W-1:0] = pptr_q;
			end else if (paddr_i == REG_PDATA) begin
				prdata_d[PW-1:0] = pmem[pptr_q];
			end else begin
				pslverr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o  <= '0;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			busy_o    <= 1'b0;
		end else begin
			prdata_o  <= prdata_d;
			pready_o  <= pready_d;
			pslverr_o <= pslverr_d;
			busy_o    <= (state_d != ST_IDLE);
		end
	end

endmodule

// *** testbench/msx_chk_sva.sv ***
// Port checker for the swap, skip, table and xor execution unit
// Assumes it is bound to msx_core and sees only its ports
`timescale 1ns/10ps
module msx_chk_sva
	import msx_pkg::*;
(
	input wire logic               sys_clk_i,
	input wire logic               rst_n_i,
	input wire logic               psel_i,
	input wire logic               penable_i,
	input wire logic               pwrite_i,
	input wire logic [PADDR_W-1:0] paddr_i,
	input wire logic [PDATA_W-1:0] pwdata_i,
	input wire logic [PDATA_W-1:0] prdata_o,
	input wire logic               pready_o,
	input wire logic               pslverr_o,
	input wire logic               busy_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic setup;
	logic mapped;
	logic go;
	assign setup  = psel_i & ~penable_i;
	assign mapped = (paddr_i <= REG_PDATA) && (paddr_i[1:0] == 2'h0);
	assign go     = psel_i & penable_i & pready_o & pwrite_i & (paddr_i == REG_INSTR);

	// ----------------------------------------------------------------
	// Busy lengths of one instruction
	// ----------------------------------------------------------------
	sequence s_plain;
		busy_o ##1 !busy_o;
	endsequence
	sequence s_skipped;
		busy_o[*2] ##1 !busy_o;
	endsequence

	AST_READY_AFTER_SETUP: assert property (setup |=> pready_o)
		else $error("ready missing after setup");
	AST_READY_PULSE: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	AST_READY_CAUSE: assert property (pready_o |-> $past(setup))
		else $error("ready without setup");
	AST_ERR_UNMAPPED: assert property (setup && !mapped |=> pslverr_o)
		else $error("no error on unmapped address");
	AST_ERR_MAPPED: assert property (setup && mapped |=> !pslverr_o)
		else $error("error on mapped address");
	AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == '0)
		else $error("read data outside access");
	AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> $past(go))
		else $error("busy without instruction write");
	AST_EXEC_LEN: assert property (go && !busy_o |=> (s_plain or s_skipped))
		else $error("instruction length not one or two cycles");
	AST_RDATA_UPPER: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
endmodule

// *** testbench/msx_apb_master.sv ***
// APB master standing in for the software side of the unit
// Assumes xfer is called from the bench at any time; it waits for an edge first
`timescale 1ns/10ps
module msx_apb_master
	import msx_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic [PDATA_W-1:0] prdata_i,
	input  wire logic               pready_i,
	input  wire logic               pslverr_i,
	output logic                    psel_o,
	output logic                    penable_o,
	output logic                    pwrite_o,
	output logic      [PADDR_W-1:0] paddr_o,
	output logic      [PDATA_W-1:0] pwdata_o
);
	initial begin
		psel_o    = 1'b0;
		penable_o = 1'b0;
		pwrite_o  = 1'b0;
		paddr_o   = 8'h00;
		pwdata_o  = 32'h0000_0000;
	end

	// Request held until ready seen; data taken in that cycle
	task automatic xfer(input logic w, input logic [PADDR_W-1:0] a,
		input logic [PDATA_W-1:0] d, output logic [PDATA_W-1:0] q, output logic e);
		@(posedge clk_i);
		psel_o    <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o  <= w;
		paddr_o   <= a;
		pwdata_o  <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_i !== 1'b1);
		q = prdata_i;
		e = pslverr_i;
		psel_o    <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule

// *** testbench/tb_mcu_swap_skip_table_xor_exec.sv ***
// Self-checking bench of the swap, skip, table and xor execution unit
// Assumes msx_core with its APB port; instructions run from INSTR writes
`timescale 1ns/10ps
module tb_mcu_swap_skip_table_xor_exec;
	import msx_pkg::*;
	logic               sys_clk;
	logic               rst_n;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [PADDR_W-1:0] paddr;
	logic [PDATA_W-1:0] pwdata;
	logic [PDATA_W-1:0] prdata;
	logic               pready;
	logic               pslverr;
	logic               busy;
	logic [PDATA_W-1:0] q;
	logic               e;
	int                 n_errors;
	int                 n_compared;
	int                 cyc;

	msx_core uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .busy_o(busy));
	msx_apb_master mst (.clk_i(sys_clk), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic [PADDR_W-1:0] a, input logic [PDATA_W-1:0] d);
		mst.xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [PADDR_W-1:0] a, input logic [PDATA_W-1:0] ex, input string nm);
		mst.xfer(1'b0, a, 32'h0000_0000, q, e);
		chk(nm, ex, q);
	endtask

	task automatic setm(input logic [DA_W-1:0] a, input logic [DW-1:0] v);
		wr(REG_DPTR, {26'h0, a});
		wr(REG_DDATA, {24'h0, v});
	endtask

	// Returns how many cycles busy stood
	task automatic exe(input logic [OPC_W-1:0] op, input logic [BIT_W-1:0] b,
		input logic [DA_W-1:0] m, input logic [DW-1:0] im, output int n);
		wr(REG_INSTR, {8'h00, im, 2'h0, m, 1'b0, b, op});
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (busy === 1'b1);
		n = n - 1;
	endtask

	task automatic t_apb();
		rd(REG_ACC, 32'h0, "acc_reset");
		rd(REG_STATUS, 32'h0, "status_reset");
		rd(8'h40, 32'h0, "unmapped_data");
		chk("unmapped_err", 32'h1, {31'h0, e});
		wr(8'h40, 32'h0000_005A);
		chk("unmapped_wr_err", 32'h1, {31'h0, e});
		rd(REG_INSTR, 32'h0, "instr_read");
		$display("Test apb done");
	endtask

	task automatic t_swap();
		int n;
		wr(REG_STATUS, 32'h1);
		setm(6'h05, 8'h3C);
		exe(OP_NIBBLE_SWAP_TO_ACC, 3'h0, 6'h05, 8'h00, n);
		chk("cycles", 32'h1, n);
		rd(REG_ACC, 32'hC3, "acc");
		rd(REG_DDATA, 32'h3C, "mem");
		rd(REG_STATUS, 32'h1, "status");
		exe(OP_NOP, 3'h0, 6'h05, 8'h00, n);
		chk("nop_cycles", 32'h1, n);
		rd(REG_ACC, 32'hC3, "nop_acc");
		rd(REG_DDATA, 32'h3C, "nop_mem");
		$display("Test swap done");
	endtask

	task automatic run_skip(input logic [OPC_W-1:0] op, input logic [BIT_W-1:0] b,
		input logic [DW-1:0] v, input logic sk);
		int n;
		logic [DW-1:0] ea;
		ea = (op == OP_COPY_AND_SKIP) ? v : 8'hA5;
		wr(REG_ACC, 32'hA5);
		wr(REG_STATUS, 32'h1);
		wr(REG_PC, 32'h10);
		setm(6'h07, v);
		exe(op, b, 6'h07, 8'h00, n);
		chk("cycles", sk ? 32'h2 : 32'h1, n);
		rd(REG_PC, sk ? 32'h12 : 32'h11, "pc");
		rd(REG_STATUS, {29'h0, sk, 2'h1}, "status");
		rd(REG_ACC, {24'h0, ea}, "acc");
		rd(REG_DDATA, {24'h0, v}, "mem");
	endtask

	task automatic t_skip();
		run_skip(OP_SKIP_IF_NULL, 3'h0, 8'h00, 1'b1);
		run_skip(OP_SKIP_IF_NULL, 3'h0, 8'h80, 1'b0);
		run_skip(OP_COPY_AND_SKIP, 3'h0, 8'h00, 1'b1);
		run_skip(OP_COPY_AND_SKIP, 3'h0, 8'h01, 1'b0);
		run_skip(OP_SKIP_IF_BIT_NULL, 3'h3, 8'hF7, 1'b1);
		run_skip(OP_SKIP_IF_BIT_NULL, 3'h0, 8'h01, 1'b0);
		run_skip(OP_SKIP_IF_BIT_NULL, 3'h7, 8'h7F, 1'b1);
		run_skip(OP_SKIP_IF_BIT_NULL, 3'h7, 8'h80, 1'b0);
		$display("Test skip done");
	endtask

	task automatic run_tab(input logic [OPC_W-1:0] op, input logic [DA_W-1:0] m,
		input logic [PW-1:0] w);
		int n;
		wr(REG_PC, 32'h1F0);
		exe(op, 3'h0, m, 8'h00, n);
		wr(REG_DPTR, {26'h0, m});
		rd(REG_DDATA, {24'h0, w[7:0]}, "table_low");
		rd(REG_THLAT, {24'h0, w[15:8]}, "table_high");
		rd(REG_STATUS, 32'h1, "status");
	endtask

	task automatic t_table();
		logic [PA_W-1:0] pa [4] = '{10'h034, 10'h134, 10'h234, 10'h334};
		logic [PW-1:0]   pw [4] = '{16'h9ABC, 16'h1357, 16'hBEEF, 16'h2468};
		for (int i = 0; i < 4; i++) begin
			wr(REG_PPTR, {22'h0, pa[i]});
			wr(REG_PDATA, {16'h0, pw[i]});
		end
		wr(REG_TPLOW, 32'h34);
		wr(REG_TPHIGH, 32'h2);
		wr(REG_STATUS, 32'h1);
		run_tab(OP_TABLE_READ_SPECIFIC, 6'h0A, 16'hBEEF);
		run_tab(OP_TABLE_READ_CURRENT, 6'h0B, 16'h1357);
		run_tab(OP_TABLE_READ_LAST, 6'h0C, 16'h2468);
		$display("Test table done");
	endtask

	task automatic run_xor(input logic [OPC_W-1:0] op, input logic [DW-1:0] a0,
		input logic [DW-1:0] m0, input logic [DW-1:0] im, input logic [DW-1:0] ea,
		input logic [DW-1:0] em, input logic z);
		int n;
		wr(REG_ACC, {24'h0, a0});
		wr(REG_STATUS, {31'h0, ~z});
		setm(6'h09, m0);
		exe(op, 3'h0, 6'h09, im, n);
		rd(REG_ACC, {24'h0, ea}, "acc");
		rd(REG_DDATA, {24'h0, em}, "mem");
		rd(REG_STATUS, {31'h0, z}, "zero_flag");
	endtask

	task automatic t_xor();
		run_xor(OP_XOR_TO_ACC, 8'h5A, 8'h5A, 8'h00, 8'h00, 8'h5A, 1'b1);
		run_xor(OP_XOR_TO_ACC, 8'h0F, 8'hF0, 8'h00, 8'hFF, 8'hF0, 1'b0);
		run_xor(OP_EXCLUSIVE_OR_TO_MEMORY, 8'hF0, 8'h0F, 8'h00, 8'hF0, 8'hFF, 1'b0);
		run_xor(OP_EXCLUSIVE_OR_TO_MEMORY, 8'h3C, 8'h3C, 8'h00, 8'h3C, 8'h00, 1'b1);
		run_xor(OP_XOR_IMMEDIATE, 8'h33, 8'h77, 8'h33, 8'h00, 8'h77, 1'b1);
		run_xor(OP_XOR_IMMEDIATE, 8'h33, 8'h77, 8'h01, 8'h32, 8'h77, 1'b0);
		$display("Test xor done");
	endtask

	initial begin
		rst_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_apb();
		t_swap();
		t_skip();
		t_table();
		t_xor();
		stop_test();
	end
endmodule

bind msx_core msx_chk_sva chk_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o));
